// ===== scs_pkg.sv
// Shared constants and types for the system clock switcher.
package scs_pkg;
   // Register byte offsets on the Avalon-MM slave port.
   localparam logic [4:0] SCS_OFF_REQUEST = 5'h00;
   localparam logic [4:0] SCS_OFF_CURRENT = 5'h04;
   localparam logic [4:0] SCS_OFF_SWCTRL = 5'h08;
   localparam logic [4:0] SCS_OFF_OSC_READY_STATUS = 5'h0C;
   localparam logic [4:0] SCS_OFF_OSC_MANUAL_ENABLE = 5'h10;
   localparam logic [4:0] SCS_OFF_FREQ = 5'h14;
   localparam logic [4:0] SCS_OFF_TRIM = 5'h18;
   localparam logic [4:0] SCS_OFF_IRQ = 5'h1C;
   // Field widths and positions.
   localparam int SCS_SRC_W = 3;
   localparam int SCS_DIV_W = 4;
   localparam int SCS_REQUESTED_SOURCE = 8;
   localparam int SCS_FRQ_W = 4;
   localparam int SCS_TRIM_W = 6;
   localparam int SCS_SRC_LSB = 4;
   localparam int SCS_HOLD_BIT = 7;
   localparam int SCS_SOURCE_READY_BIT = 4;
   localparam int SCS_NEW_SOURCE_READY_BIT = 3;
   localparam int SCS_IF_BIT = 0;
   localparam int SCS_IE_BIT = 1;
   // Oscillator slots in the ready and enable vectors.
   localparam int SCS_IDX_FAST = 6;
   localparam int SCS_IDX_MID = 5;
   localparam int SCS_IDX_PLL = 1;
   localparam int SCS_IDX_CONVERTER_RC_OSC = 2;
   // Reset values.
   localparam logic [SCS_SRC_W-1:0] SCS_RST_SRC = 3'h6;
   localparam logic [SCS_DIV_W-1:0] SCS_RST_DIV = 4'h0;
   localparam logic [SCS_FRQ_W-1:0] SCS_RST_FRQ = 4'h2;
   localparam logic [SCS_TRIM_W-1:0] SCS_RST_TRIM = 6'h00;
   // Timing: settle time of the fast oscillator after a retune, in ns.
   localparam int SCS_CLK_NS = 20;
   localparam int SCS_SETTLE_NS = 200;
   localparam int SCS_SETTLE_CYC =
      (SCS_SETTLE_NS + SCS_CLK_NS - 1) / SCS_CLK_NS;
   // Dead time between gating the old clock and opening the new one.
   localparam int SCS_GAP_NS = 60;
   localparam int SCS_GAP_CYC = (SCS_GAP_NS + SCS_CLK_NS - 1) / SCS_CLK_NS;
   // Switch sequencer states, one-hot.
   typedef enum logic [3:0] {
      SCS_IDLE = 4'h1,
      SCS_WAIT = 4'h2,
      SCS_HOLD = 4'h4,
      SCS_SWAP = 4'h8
   } scs_state_t;
   // Handover unit states, one-hot.
   typedef enum logic [2:0] {
      SCS_H_RUN = 3'h1,
      SCS_H_GAP = 3'h2,
      SCS_H_OPEN = 3'h4
   } scs_hstate_t;
endpackage

// ===== scs_handover_if.sv
// Interface between the switch sequencer and the handover unit.
`timescale 1ns/1ps
interface scs_handover_if;
   import scs_pkg::*;
   logic start; // Pulse: begin a handover to target.
   logic [SCS_SRC_W-1:0] target_src; // Source to hand over to.
   logic [SCS_DIV_W-1:0] target_div; // Divider to hand over to.
   logic done; // Pulse: new selection is live.
   logic busy; // Level: a handover is in progress.
   modport ctrl (output start, output target_src, output target_div,
      input done, input busy);
   modport unit (input start, input target_src, input target_div,
      output done, output busy);
endinterface

// ===== scs_handover.sv
// Break-before-make handover of the system clock selection.
`timescale 1ns/1ps
module scs_handover
   import scs_pkg::*;
#(
   parameter int GAP_CYC = SCS_GAP_CYC
) (
   input wire logic clock,
   input wire logic rst_b,
   scs_handover_if.unit hif,
   output logic sys_clk_gate,
   output logic [SCS_SRC_W-1:0] sys_clk_sel,
   output logic [SCS_DIV_W-1:0] sys_clk_div
);
   scs_hstate_t state; // Handover phase.
   scs_hstate_t next_state; // Phase for the next edge.
   logic [7:0] gap_cnt; // Dead-time counter while both clocks are gated.
   wire gap_over = (gap_cnt == 8'(GAP_CYC - 1)); // Dead time elapsed.

   // The gate is closed before the mux moves and opened only after the
   // dead time, so neither clock can leave a truncated pulse behind.
   always_comb begin
      next_state = state;
      unique case (state)
         SCS_H_RUN: if (hif.start) next_state = SCS_H_GAP;
         SCS_H_GAP: if (gap_over) next_state = SCS_H_OPEN;
         SCS_H_OPEN: next_state = SCS_H_RUN;
      endcase
   end

   // Phase register and dead-time count.
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         state <= SCS_H_RUN;
         gap_cnt <= 8'h00;
      end else begin
         state <= next_state;
         gap_cnt <= (state == SCS_H_GAP) ? gap_cnt + 8'h01 : 8'h00;
      end
   end

   // Selection moves only while the gate is shut.
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         sys_clk_gate <= 1'b1;
         sys_clk_sel <= SCS_RST_SRC;
         sys_clk_div <= SCS_RST_DIV;
      end else begin
         if (state == SCS_H_RUN && hif.start) begin
            sys_clk_gate <= 1'b0;
         end
         if (state == SCS_H_GAP && gap_over) begin
            sys_clk_sel <= hif.target_src;
            sys_clk_div <= hif.target_div;
         end
         if (state == SCS_H_OPEN) begin
            sys_clk_gate <= 1'b1;
         end
      end
   end

   assign hif.done = (state == SCS_H_OPEN);
   assign hif.busy = (state != SCS_H_RUN);
endmodule // scs_handover

// ===== scs_switcher.sv
// System clock source and divider switcher with Avalon-MM registers.
// Overview of operation
// - Frequency rewrite clears fast and mid ready.
// - Mid clock stalls until fast oscillator restarts.
// - Old source clocks until new one ready.
// - Already running source counts ready at once.
// - New source ready sets status and flag.
// - Interrupt raised only when enable bit set.
// - Switch flag never wakes from sleep.
// - Without hold, switch as soon as ready.
// - With hold, stay on old clock.
// - Reduced-rate mode does not slow the switch.
// - Divider-only change follows same held sequence.
// - Current fields update at switch; ready sets.
// - Hardware clears new-ready when switch completes.
// - One register shows every oscillator ready.
// - Manual oscillator enable excludes the PLL.
`timescale 1ns/1ps
module scs_switcher
   import scs_pkg::*;
#(
   parameter int SETTLE_CYC = SCS_SETTLE_CYC,
   parameter int GAP_CYC = SCS_GAP_CYC
) (
   input wire logic clock,
   input wire logic rst_b,
   // Avalon-MM slave.
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Oscillator block.
   input wire logic [SCS_REQUESTED_SOURCE-1:0] osc_ready_raw,
   output logic [SCS_REQUESTED_SOURCE-1:0] osc_run,
   output logic [SCS_FRQ_W-1:0] internal_freq_select,
   output logic [SCS_TRIM_W-1:0] trim_value,
   output logic mid_internal_osc_en,
   // Core side.
   input wire logic reduced_rate_exec,
   input wire logic ext_wake,
   output logic cpu_wake,
   output logic switch_irq,
   // System clock mux control.
   output logic sys_clk_gate,
   output logic [SCS_SRC_W-1:0] sys_clk_sel,
   output logic [SCS_DIV_W-1:0] sys_clk_div
);
   // Register state.
   logic [SCS_SRC_W-1:0] requested_source; // Pending source code.
   logic [SCS_DIV_W-1:0] requested_divider; // Pending divider code.
   logic [SCS_SRC_W-1:0] current_source; // Source now in use.
   logic [SCS_DIV_W-1:0] current_divider; // Divider now in use.
   logic switch_hold; // Software hold on the handover.
   logic new_source_ready; // Requested source is ready.
   logic source_ready; // Last switch has completed.
   logic switch_irq_flag; // Sticky switch event.
   logic switch_irq_enable; // Lets the flag reach the interrupt line.
   logic [SCS_REQUESTED_SOURCE-1:0] osc_manual_enable; // Forced oscillators.
   logic freq_pending; // Retune of the fast oscillator in progress.
   logic [7:0] settle_cnt; // Unbroken run of fast ready cycles seen during a retune.
   logic bus_ack; // Second cycle of a bus access.
   scs_state_t state; // Switch sequencer phase.
   scs_state_t next_state; // Phase for the next edge.
   scs_handover_if hif ();

   // Returns a one-hot slot mask for a source code.
   function automatic logic [SCS_REQUESTED_SOURCE-1:0] src_mask(
      input logic [SCS_SRC_W-1:0] code);
      src_mask = SCS_REQUESTED_SOURCE'(1) << code;
   endfunction

   // Bus decode: an access completes on its second cycle.
   wire bus_req = avs_read | avs_write;
   wire wr_en = avs_write & bus_ack;
   wire wr_request = wr_en && (avs_address == SCS_OFF_REQUEST);
   wire wr_swctrl = wr_en && (avs_address == SCS_OFF_SWCTRL);
   wire wr_osc_manual_enable = wr_en && (avs_address == SCS_OFF_OSC_MANUAL_ENABLE);
   wire wr_freq = wr_en && (avs_address == SCS_OFF_FREQ);
   wire wr_trim = wr_en && (avs_address == SCS_OFF_TRIM);
   wire wr_irq = wr_en && (avs_address == SCS_OFF_IRQ);
   wire [SCS_SRC_W-1:0] wd_src =
      avs_writedata[SCS_SRC_LSB +: SCS_SRC_W];
   wire [SCS_DIV_W-1:0] wd_div = avs_writedata[SCS_DIV_W-1:0];

   // Ready view: the fast and mid oscillators read not ready while a
   // retune is pending, whatever the analog block says.
   wire [SCS_REQUESTED_SOURCE-1:0] retune_mask =
      src_mask(3'(SCS_IDX_FAST)) | src_mask(3'(SCS_IDX_MID));
   wire [SCS_REQUESTED_SOURCE-1:0] osc_ready_status =
      osc_ready_raw & ~(freq_pending ? retune_mask : '0);

   // A request naming the source in use is ready at once; otherwise the
   // requested oscillator's own ready decides.
   wire same_src = (requested_source == current_source);
   wire req_ready = same_src |
      (|(osc_ready_status & src_mask(requested_source)));
   wire req_differs = !same_src ||
      (requested_divider != current_divider);
   wire ready_event = (state == SCS_WAIT) && req_ready;

   // Sequencer next state.
   always_comb begin
      next_state = state;
      unique case (state)
         SCS_IDLE: if (req_differs) next_state = SCS_WAIT;
         SCS_WAIT: begin
            if (!req_differs) begin
               next_state = SCS_IDLE;
            end else if (req_ready) begin
               next_state = switch_hold ? SCS_HOLD : SCS_SWAP;
            end
         end
         SCS_HOLD: begin
            if (!req_differs) begin
               next_state = SCS_IDLE;
            end else if (!switch_hold) begin
               next_state = SCS_SWAP;
            end
         end
         // Handover runs on every edge, so it finishes even when the
         // core is skipping cycles in reduced-rate mode.
         SCS_SWAP: if (hif.done) next_state = SCS_IDLE;
      endcase
   end

   // Sequencer phase register.
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         state <= SCS_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Start the handover once, on entry to the swap phase; the target is
   // the request as it stood when accepted.
   assign hif.start = (state != SCS_SWAP) && (next_state == SCS_SWAP);
   assign hif.target_src = requested_source;
   assign hif.target_div = requested_divider;

   // Request register; writes are ignored in the swap phase, and a request that differs from the current setting clears the completion status.
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         requested_source <= SCS_RST_SRC;
         requested_divider <= SCS_RST_DIV;
      end else if (wr_request && state != SCS_SWAP) begin
         requested_source <= wd_src;
         requested_divider <= wd_div;
      end
   end

   // Current fields hold the old setting until the handover is done.
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         current_source <= SCS_RST_SRC;
         current_divider <= SCS_RST_DIV;
      end else if (hif.done) begin
         current_source <= requested_source;
         current_divider <= requested_divider;
      end
   end

   // Switch status: new-ready sets on the ready event and is cleared by
   // hardware at completion or when a held request is cancelled.
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         new_source_ready <= 1'b0;
         source_ready <= 1'b1;
      end else begin
         if (hif.done || (state == SCS_HOLD && !req_differs)) begin
            new_source_ready <= 1'b0;
         end else if (ready_event) begin
            new_source_ready <= 1'b1;
         end
         if (hif.done) begin
            source_ready <= 1'b1;
         end else if (state == SCS_IDLE && req_differs) begin
            source_ready <= 1'b0;
         end
      end
   end

   // Hold bit and the interrupt bits; a ready event wins over a clear
   // written in the same cycle.
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         switch_hold <= 1'b0;
         switch_irq_flag <= 1'b0;
         switch_irq_enable <= 1'b0;
      end else begin
         if (wr_swctrl) begin
            switch_hold <= avs_writedata[SCS_HOLD_BIT];
         end
         if (ready_event) begin
            switch_irq_flag <= 1'b1;
         end else if (wr_irq && avs_writedata[SCS_IF_BIT]) begin
            switch_irq_flag <= 1'b0;
         end
         if (wr_irq) begin
            switch_irq_enable <= avs_writedata[SCS_IE_BIT];
         end
      end
   end

   // Manual enables; the PLL slot cannot be forced on.
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         osc_manual_enable <= '0;
      end else if (wr_osc_manual_enable) begin
         osc_manual_enable <= avs_writedata[SCS_REQUESTED_SOURCE-1:0] &
            ~src_mask(3'(SCS_IDX_PLL));
      end
   end

   // Frequency select and trim. A new frequency starts a retune that ends
   // only after the fast oscillator has reported ready for the settle
   // time, which filters a ready level left over from before the change.
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         internal_freq_select <= SCS_RST_FRQ;
         trim_value <= SCS_RST_TRIM;
         freq_pending <= 1'b0;
         settle_cnt <= 8'h00;
      end else begin
         if (wr_freq) begin
            internal_freq_select <= avs_writedata[SCS_FRQ_W-1:0];
            freq_pending <= 1'b1;
            settle_cnt <= 8'h00;
         end else if (freq_pending) begin
            if (!osc_ready_raw[SCS_IDX_FAST]) begin
               settle_cnt <= 8'h00;
            end else if (settle_cnt == 8'(SETTLE_CYC - 1)) begin
               freq_pending <= 1'b0;
            end else begin
               settle_cnt <= settle_cnt + 8'h01;
            end
         end
         if (wr_trim) begin
            trim_value <= avs_writedata[SCS_TRIM_W-1:0];
         end
      end
   end

   // The mid clock is held at a static level during a retune.
   assign mid_internal_osc_en = !freq_pending;

   // Keep the running, requested and forced oscillators alive so the old
   // clock never stops before the handover.
   assign osc_run = src_mask(current_source) | src_mask(requested_source)
      | osc_manual_enable | src_mask(3'(SCS_IDX_CONVERTER_RC_OSC));

   // Interrupt line; the wake path deliberately leaves the flag out.
   assign switch_irq = switch_irq_flag & switch_irq_enable;
   assign cpu_wake = ext_wake;

   // Read mux; unmapped offsets read as zero.
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (avs_address)
         SCS_OFF_REQUEST: rd_mux = 32'({requested_source,
            requested_divider});
         SCS_OFF_CURRENT: rd_mux = 32'({current_source,
            current_divider});
         SCS_OFF_SWCTRL: begin
            rd_mux[SCS_HOLD_BIT] = switch_hold;
            rd_mux[SCS_SOURCE_READY_BIT] = source_ready;
            rd_mux[SCS_NEW_SOURCE_READY_BIT] = new_source_ready;
         end
         SCS_OFF_OSC_READY_STATUS: rd_mux = 32'(osc_ready_status);
         SCS_OFF_OSC_MANUAL_ENABLE: rd_mux = 32'(osc_manual_enable);
         SCS_OFF_FREQ: rd_mux = 32'(internal_freq_select);
         SCS_OFF_TRIM: rd_mux = 32'(trim_value);
         SCS_OFF_IRQ: rd_mux = 32'({switch_irq_enable, switch_irq_flag});
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // One wait state per access; read data is registered in the first
   // cycle and stands while waitrequest is low.
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         bus_ack <= 1'b0;
         avs_readdata <= 32'h0000_0000;
      end else begin
         bus_ack <= bus_req & ~bus_ack;
         if (avs_read && !bus_ack) begin
            avs_readdata <= rd_mux;
         end
      end
   end
   assign avs_waitrequest = bus_req & ~bus_ack;

   // Glitch-free handover unit.
   scs_handover #(
      .GAP_CYC(GAP_CYC)
   ) u_handover (
      .clock(clock),
      .rst_b(rst_b),
      .hif(hif.unit),
      .sys_clk_gate(sys_clk_gate),
      .sys_clk_sel(sys_clk_sel),
      .sys_clk_div(sys_clk_div)
   );
endmodule // scs_switcher

// ===== scs_switcher_asserts.sv
// Concurrent checks on the clock switcher's top-level ports.
`timescale 1ns/1ps
module scs_switcher_asserts
   import scs_pkg::*;
#(
   parameter int SETTLE_CYC = SCS_SETTLE_CYC,
   parameter int GAP_CYC = SCS_GAP_CYC
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic [SCS_REQUESTED_SOURCE-1:0] osc_ready_raw,
   input wire logic [SCS_REQUESTED_SOURCE-1:0] osc_run,
   input wire logic [SCS_FRQ_W-1:0] internal_freq_select,
   input wire logic [SCS_TRIM_W-1:0] trim_value,
   input wire logic mid_internal_osc_en,
   input wire logic reduced_rate_exec,
   input wire logic ext_wake,
   input wire logic cpu_wake,
   input wire logic switch_irq,
   input wire logic sys_clk_gate,
   input wire logic [SCS_SRC_W-1:0] sys_clk_sel,
   input wire logic [SCS_DIV_W-1:0] sys_clk_div
);
   // All checks share the one clock and the asynchronous reset.
   default clocking dc @(posedge clock); endclocking
   default disable iff (!rst_b);
   // A register write accepted at this edge.
   wire wr_ok = avs_write && !avs_waitrequest;
   // The gate stays shut a while, then reopens within a short bound.
   sequence s_dead_time;
      !sys_clk_gate ##[1:8] sys_clk_gate;
   endsequence
   a_one_wait: assert property ($rose(avs_read || avs_write) |->
      avs_waitrequest ##1 !avs_waitrequest) else $error("wait state wrong");
   a_irq_masked: assert property (
      (wr_ok && avs_address == SCS_OFF_IRQ && !avs_writedata[SCS_IE_BIT])
      |=> !switch_irq) else $error("irq raised while disabled");
   a_no_wake: assert property (cpu_wake == ext_wake)
      else $error("wake output differs from wake input");
   a_sel_gated: assert property (!$stable(sys_clk_sel) |->
      !sys_clk_gate && !$past(sys_clk_gate)) else $error("sel moved open");
   a_div_gated: assert property (!$stable(sys_clk_div) |->
      !sys_clk_gate) else $error("divider moved while gate open");
   a_gate_gap: assert property ($fell(sys_clk_gate) |=> s_dead_time)
      else $error("gate dead time wrong");
   a_freq_stall: assert property (
      (wr_ok && avs_address == SCS_OFF_FREQ) |=> !mid_internal_osc_en)
      else $error("mid clock not stalled after retune");
   a_mid_resume: assert property ($rose(mid_internal_osc_en) |->
      $past(osc_ready_raw[SCS_IDX_FAST])) else $error("mid resumed early");
   a_old_runs: assert property (osc_run[sys_clk_sel])
      else $error("selected oscillator not running");
endmodule // scs_switcher_asserts

// ===== tb.sv
// Self-checking testbench for the system clock switcher.
`timescale 1ns/1ps
module tb
   import scs_pkg::*;
;
   localparam int SETTLE_CYC = 2; // Short retune settle keeps runs brief.
   localparam int GAP_CYC = 1; // Short dead time, same reason.
   logic clock, rst_b, avs_read, avs_write, avs_waitrequest;
   logic [4:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic [31:0] rnd; // Random write data, kept apart from the bus pins.
   logic [SCS_REQUESTED_SOURCE-1:0] osc_ready_raw, osc_run;
   logic [SCS_FRQ_W-1:0] internal_freq_select;
   logic [SCS_TRIM_W-1:0] trim_value;
   logic mid_internal_osc_en, reduced_rate_exec, ext_wake, cpu_wake;
   logic switch_irq, sys_clk_gate;
   logic [SCS_SRC_W-1:0] sys_clk_sel;
   logic [SCS_DIV_W-1:0] sys_clk_div;
   int fails, total_checks, seed, m_src, m_div, n;
   scs_switcher #(.SETTLE_CYC(SETTLE_CYC), .GAP_CYC(GAP_CYC)) uut (
      .clock(clock), .rst_b(rst_b), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .osc_ready_raw(osc_ready_raw),
      .osc_run(osc_run), .internal_freq_select(internal_freq_select),
      .trim_value(trim_value), .mid_internal_osc_en(mid_internal_osc_en),
      .reduced_rate_exec(reduced_rate_exec), .ext_wake(ext_wake),
      .cpu_wake(cpu_wake), .switch_irq(switch_irq),
      .sys_clk_gate(sys_clk_gate), .sys_clk_sel(sys_clk_sel),
      .sys_clk_div(sys_clk_div));
   // Free-running 50 MHz clock.
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   // Compares one value and counts the outcome.
   task chk(input string what, input logic [31:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // One Avalon access; holds the request until waitrequest is low.
   task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      @(posedge clock);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata; // Read data is taken at the accepting edge.
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   // Reads a register and compares it under a mask.
   task rdchk(input string what, input logic [4:0] a, input logic [31:0] m,
      input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(what, rd & m, e);
   endtask
   // Waits, bounded, for the mux to settle on the model's selection.
   task wait_sel();
      n = 0;
      while ((sys_clk_sel !== m_src[2:0] || sys_clk_div !== m_div[3:0] ||
         sys_clk_gate !== 1'b1) && n < 100) begin
         @(posedge clock);
         n++;
      end
      chk("sys_clk_sel", {sys_clk_div, 1'b0, sys_clk_sel}, {m_div[3:0],
         1'b0, m_src[2:0]});
   endtask
   // Prints the counts and the verdict, then stops.
   task end_of_test();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Watchdog: the tests need well under this span.
   initial begin
      repeat (20000) @(posedge clock);
      fails++;
      end_of_test();
   end
   // Main sequence; the model tracks the live source and divider.
   initial begin
      seed = 32'h566B;
      {rst_b, avs_read, avs_write, avs_address, avs_writedata} = '0;
      osc_ready_raw = 8'h40;
      reduced_rate_exec = 1'b1; // The switch must not wait on the CPU.
      ext_wake = 1'b0;
      m_src = SCS_RST_SRC;
      m_div = SCS_RST_DIV;
      repeat (3) @(posedge clock);
      rst_b <= 1'b1;
      rdchk("current", SCS_OFF_CURRENT, 32'h7F, 32'h60);
      rdchk("freq", SCS_OFF_FREQ, 32'hFF, 32'h02);
      rdchk("trim", SCS_OFF_TRIM, 32'hFF, 32'h00);
      rdchk("unmapped", 5'h02, 32'hFFFFFFFF, 32'h0);
      rnd = $random(seed);
      bus(1'b1, SCS_OFF_TRIM, rnd);
      rdchk("trim", SCS_OFF_TRIM, 32'h3F, {26'h0, rnd[5:0]});
      chk("trim_value", trim_value, rnd[5:0]);
      ext_wake <= 1'($random(seed));
      $display("test reset and registers done");
      // Switch to the mid source, which is not yet ready.
      bus(1'b1, SCS_OFF_IRQ, 32'h2);
      chk("cpu_wake", cpu_wake, ext_wake);
      bus(1'b1, SCS_OFF_REQUEST, 32'h53);
      repeat (5) @(posedge clock);
      chk("sel held", sys_clk_sel, 3'h6);
      rdchk("new_source_ready", SCS_OFF_SWCTRL, 32'h08, 32'h0);
      osc_ready_raw <= 8'h60;
      m_src = 5;
      m_div = 3;
      wait_sel();
      chk("switch_irq", switch_irq, 1'b1);
      rdchk("current", SCS_OFF_CURRENT, 32'h7F, 32'h53);
      rdchk("source_ready new_source_ready", SCS_OFF_SWCTRL, 32'h18, 32'h10);
      rdchk("irq reg", SCS_OFF_IRQ, 32'h3, 32'h3);
      bus(1'b1, SCS_OFF_IRQ, 32'h1);
      @(posedge clock);
      chk("switch_irq", switch_irq, 1'b0);
      $display("test plain switch done");
      // Held switch to a running source, then cancelled by copy.
      bus(1'b1, SCS_OFF_SWCTRL, 32'h80);
      bus(1'b1, SCS_OFF_REQUEST, 32'h60);
      repeat (4) @(posedge clock);
      rdchk("held", SCS_OFF_SWCTRL, 32'h88, 32'h88);
      chk("sel held", sys_clk_sel, 3'h5);
      rdchk("flag", SCS_OFF_IRQ, 32'h3, 32'h1);
      chk("switch_irq", switch_irq, 1'b0);
      bus(1'b1, SCS_OFF_REQUEST, 32'h53);
      repeat (3) @(posedge clock);
      rdchk("cancel", SCS_OFF_SWCTRL, 32'h08, 32'h0);
      chk("sel kept", sys_clk_sel, 3'h5);
      // Divider-only change completes once the hold is released.
      bus(1'b1, SCS_OFF_REQUEST, 32'h57);
      repeat (3) @(posedge clock);
      chk("div held", sys_clk_div, 4'h3);
      bus(1'b1, SCS_OFF_SWCTRL, 32'h0);
      m_div = 7;
      wait_sel();
      rdchk("current", SCS_OFF_CURRENT, 32'h7F, 32'h57);
      bus(1'b1, SCS_OFF_IRQ, 32'h1);
      $display("test held switch done");
      // Retune: fast and mid ready read low until the fast one settles.
      osc_ready_raw <= 8'h20;
      bus(1'b1, SCS_OFF_FREQ, 32'h5);
      @(posedge clock);
      chk("mid stalled", mid_internal_osc_en, 1'b0);
      rdchk("status", SCS_OFF_OSC_READY_STATUS, 32'hFF, 32'h00);
      osc_ready_raw <= 8'h64;
      n = 0;
      while (mid_internal_osc_en !== 1'b1 && n < 50) begin
         @(posedge clock);
         n++;
      end
      rdchk("status", SCS_OFF_OSC_READY_STATUS, 32'hFF, 32'h64);
      chk("freq", internal_freq_select, 4'h5);
      bus(1'b1, SCS_OFF_OSC_MANUAL_ENABLE, 32'hFF);
      rdchk("manual en", SCS_OFF_OSC_MANUAL_ENABLE, 32'hFF, 32'hFD);
      chk("osc_run", osc_run, 8'hFD);
      $display("test oscillator status done");
      end_of_test();
   end
endmodule // tb
bind scs_switcher scs_switcher_asserts #(.SETTLE_CYC(SETTLE_CYC),
   .GAP_CYC(GAP_CYC)) u_chk (.clock(clock), .rst_b(rst_b),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .osc_ready_raw(osc_ready_raw),
   .osc_run(osc_run), .internal_freq_select(internal_freq_select),
   .trim_value(trim_value), .mid_internal_osc_en(mid_internal_osc_en),
   .reduced_rate_exec(reduced_rate_exec), .ext_wake(ext_wake),
   .cpu_wake(cpu_wake), .switch_irq(switch_irq),
   .sys_clk_gate(sys_clk_gate), .sys_clk_sel(sys_clk_sel),
   .sys_clk_div(sys_clk_div));
